// ===== design/standby_pkg.sv
package standby_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] PMC_OFS = 8'h00;
	localparam logic [7:0] WDCFG_OFS = 8'h04;
	localparam logic [7:0] WDCTL_OFS = 8'h08;
	localparam logic [7:0] OSCCTL_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] OSCRUN_OFS = 8'h14;

	// Register indices returned by the decoder
	localparam logic [2:0] IDX_PMC = 3'h0;
	localparam logic [2:0] IDX_WDCFG = 3'h1;
	localparam logic [2:0] IDX_WDCTL = 3'h2;
	localparam logic [2:0] IDX_OSCCTL = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam logic [2:0] IDX_OSCRUN = 3'h5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Field positions of power_mode_control
	localparam int LIGHT_BIT = 0;
	localparam int DEEP_BIT = 1;
	localparam int SUBRET_BIT = 2;

	// Watchdog field positions and masks
	localparam int WDCFG_ARM_BIT = 4;
	localparam logic [7:0] WDCFG_CLR_MASK = 8'h07;
	localparam int WDCTL_SEL3_BIT = 3;
	localparam int WDCTL_SEL4_BIT = 4;
	localparam int WDCTL_CLR_BIT = 5;

	// Oscillator control bits dropped on full deep standby entry
	localparam logic [7:0] OSCCTL_CLR_MASK = 8'h33;

	// Oscillator run bit positions
	localparam int OSC_MAIN = 0;
	localparam int OSC_RC = 1;
	localparam int OSC_SUB = 2;
	localparam int OSC_PLL = 3;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [2:0] PMC_RST = 3'h0;
	localparam logic [7:0] WDCFG_RST = 8'h00;
	localparam logic [7:0] WDCTL_RST = 8'h00;
	localparam logic [7:0] OSCCTL_RST = 8'h00;
	localparam logic [3:0] OSCRUN_RST = 4'hb;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operating modes
	typedef enum logic [1:0]
	{
		ST_NORMAL = 2'h0,
		ST_LIGHT = 2'h1,
		ST_DEEP_FULL = 2'h3,
		ST_DEEP_SUB = 2'h2
	} mode_type;

	////////////////////////////////////////////////////////////////////////
	// Byte address to register index
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			PMC_OFS: reg_index = IDX_PMC;
			WDCFG_OFS: reg_index = IDX_WDCFG;
			WDCTL_OFS: reg_index = IDX_WDCTL;
			OSCCTL_OFS: reg_index = IDX_OSCCTL;
			STATUS_OFS: reg_index = IDX_STATUS;
			OSCRUN_OFS: reg_index = IDX_OSCRUN;
			default: reg_index = IDX_NONE;
		endcase
	endfunction

endpackage

// ===== design/mode_if.sv
`timescale 1ns/1ps
`default_nettype none

// Mode control signals between register side and mode machine
interface mode_if;
	logic rst_any;
	logic pmc_wr;
	logic [2:0] pmc_wdata;
	logic irq_accept;
	logic wake;
	logic [2:0] pmc;
	standby_pkg::mode_type state;
	logic enter_any;
	logic enter_full;

	modport fsm (input rst_any, pmc_wr, pmc_wdata, irq_accept, wake,
		output pmc, state, enter_any, enter_full);
	modport ctl (output rst_any, pmc_wr, pmc_wdata, irq_accept, wake,
		input pmc, state, enter_any, enter_full);
endinterface

`default_nettype wire

// ===== design/standby_fsm.sv
`timescale 1ns/1ps
`default_nettype none

module standby_fsm
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Mode control
	mode_if.fsm mif
);

	standby_pkg::mode_type state_ff, nxt_state;
	logic [2:0] pmc_ff, nxt_pmc;
	logic enter_any_ff, nxt_enter_any;
	logic enter_full_ff, nxt_enter_full;

	////////////////////////////////////////////////////////////////////////
	// Mode transitions and flag updates
	always_comb
	begin
		nxt_state = state_ff;
		nxt_pmc = pmc_ff;
		nxt_enter_any = 1'b0;
		nxt_enter_full = 1'b0;
		case (state_ff)
			standby_pkg::ST_NORMAL:
			begin
				if (mif.pmc_wr)
				begin
					nxt_pmc = mif.pmc_wdata;
					if (mif.pmc_wdata[standby_pkg::DEEP_BIT])
					begin
						nxt_pmc[standby_pkg::LIGHT_BIT] = 1'b1;
						nxt_enter_any = 1'b1;
						if (mif.pmc_wdata[standby_pkg::SUBRET_BIT])
						begin
							nxt_state = standby_pkg::ST_DEEP_SUB;
						end
						else
						begin
							nxt_state = standby_pkg::ST_DEEP_FULL;
							nxt_enter_full = 1'b1;
						end
					end
					else if (mif.pmc_wdata[standby_pkg::LIGHT_BIT])
					begin
						nxt_state = standby_pkg::ST_LIGHT;
						nxt_enter_any = 1'b1;
					end
				end
			end
			standby_pkg::ST_LIGHT:
			begin
				// Interrupt acceptance ends light standby
				if (mif.irq_accept)
				begin
					nxt_pmc[standby_pkg::LIGHT_BIT] = 1'b0;
					nxt_state = standby_pkg::ST_NORMAL;
				end
			end
			standby_pkg::ST_DEEP_FULL, standby_pkg::ST_DEEP_SUB:
			begin
				// Wake drops to light standby, light flag stays
				if (mif.wake)
				begin
					nxt_pmc[standby_pkg::DEEP_BIT] = 1'b0;
					nxt_state = standby_pkg::ST_LIGHT;
				end
			end
			default:
			begin
				nxt_state = standby_pkg::ST_NORMAL;
			end
		endcase
	end

	// Mode registers, cleared by any reset
	always_ff @(posedge aclk)
	begin
		if (mif.rst_any)
		begin
			state_ff <= standby_pkg::ST_NORMAL;
			pmc_ff <= standby_pkg::PMC_RST;
			enter_any_ff <= 1'b0;
			enter_full_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pmc_ff <= nxt_pmc;
			enter_any_ff <= nxt_enter_any;
			enter_full_ff <= nxt_enter_full;
		end
	end

	assign mif.state = state_ff;
	assign mif.pmc = pmc_ff;
	assign mif.enter_any = enter_any_ff;
	assign mif.enter_full = enter_full_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_light_entry: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == standby_pkg::ST_NORMAL && mif.pmc_wr && !mif.rst_any
			&& mif.pmc_wdata[1:0] == 2'h1)
		|=> (state_ff == standby_pkg::ST_LIGHT && pmc_ff[0] && enter_any_ff))
		else $error("light standby not entered");

	chk_light_exit: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == standby_pkg::ST_LIGHT && mif.irq_accept && !mif.rst_any)
		|=> (state_ff == standby_pkg::ST_NORMAL && !pmc_ff[0]))
		else $error("light standby not left on interrupt");

	chk_deep_entry: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == standby_pkg::ST_NORMAL && mif.pmc_wr && !mif.rst_any
			&& mif.pmc_wdata[1])
		|=> (pmc_ff[1:0] == 2'h3 && pmc_ff[2] == $past(mif.pmc_wdata[2])
			&& (state_ff == standby_pkg::ST_DEEP_SUB) == pmc_ff[2]))
		else $error("deep standby entry wrong");

	chk_wake_exit: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_ff inside {standby_pkg::ST_DEEP_FULL, standby_pkg::ST_DEEP_SUB}
			&& mif.wake && !mif.rst_any)
		|=> (state_ff == standby_pkg::ST_LIGHT && pmc_ff[1:0] == 2'h1))
		else $error("wake did not return to light standby");

	chk_reset_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		mif.rst_any |=> (state_ff == standby_pkg::ST_NORMAL && pmc_ff == 3'h0))
		else $error("reset did not clear mode");

endmodule // standby_fsm

`default_nettype wire

// ===== design/standby_mode_controller.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Setting the light flag alone stops execution and enters light standby.
// - Interrupt acceptance in light standby or any reset clears the light flag, resuming execution.
// - External reset pin or watchdog reset puts the CPU into reset.
// - Standby entry clears watchdog_config bits 2..0 when its bit 4 is set.
// - Standby entry clears watchdog_control bit 5 when bit 4 low, bit 3 high.
// - Deep standby entry also sets the light flag.
// - Full deep entry clears oscillator_control bits 5,4,1,0; subclock mode keeps it.
// - Light keeps oscillators; full deep stops all; reset runs all but subclock.
// - Deep flag enters full deep, or subclock standby with the retain flag set.
// - Subclock standby stops main, RC, PLL, keeps subclock and base timer.
// - Reset clears the deep flag, returning to normal; wake clears it, returning to light standby.
module standby_mode_controller
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Pins from outside
	input wire logic external_reset_pin_n,
	input wire logic port0_wake_interrupt,
	// Same-clock events
	input wire logic irq_accept,
	input wire logic watchdog_reset,
	// CPU and clock control
	output logic cpu_reset,
	output logic cpu_halt,
	output logic main_osc_run,
	output logic rc_osc_run,
	output logic sub_osc_run,
	output logic pll_osc_run,
	output logic base_timer_stop,
	output logic periph_stop
);

	mode_if mif ();

	logic rst_sync1_ff, rst_sync2_ff, wake_sync1_ff, wake_sync2_ff;
	logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, wr_fire, wr_lane;
	logic [7:0] awaddr_ff, nxt_awaddr, wbyte_ff, nxt_wbyte;
	logic wstrb0_ff, nxt_wstrb0, awready_ff, nxt_awready, wready_ff, nxt_wready;
	logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0] wdcfg_ff, nxt_wdcfg, wdctl_ff, nxt_wdctl, oscctl_ff, nxt_oscctl;
	logic [3:0] oscrun_ff, nxt_oscrun, osc_out_ff, nxt_osc_out;
	logic cpu_reset_ff, cpu_halt_ff, nxt_cpu_halt, bt_stop_ff, nxt_bt_stop;
	logic periph_stop_ff, nxt_periph_stop;
	logic [2:0] wr_idx, rd_idx;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, free running so pins settle during bus reset
	always_ff @(posedge aclk)
	begin
		rst_sync1_ff <= external_reset_pin_n;
		rst_sync2_ff <= rst_sync1_ff;
		wake_sync1_ff <= port0_wake_interrupt;
		wake_sync2_ff <= wake_sync1_ff;
	end

	// Reset sources and events toward the mode machine
	assign mif.rst_any = !aresetn || !rst_sync2_ff || watchdog_reset;
	assign mif.irq_accept = irq_accept;
	assign mif.wake = wake_sync2_ff;
	assign mif.pmc_wr = wr_fire && wr_lane && wr_idx == standby_pkg::IDX_PMC;
	assign mif.pmc_wdata = wbyte_ff[2:0];

	standby_fsm u_fsm
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.mif(mif)
	);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave handshakes
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_lane = wstrb0_ff;
	assign wr_idx = standby_pkg::reg_index(awaddr_ff);
	assign rd_idx = standby_pkg::reg_index(araddr);

	// Channel captures, responses and readies
	always_comb
	begin
		nxt_aw_got = aw_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_w_got = w_got_ff;
		nxt_wbyte = wbyte_ff;
		nxt_wstrb0 = wstrb0_ff;
		nxt_bvalid = bvalid_ff && !bready; // Response taken drops valid
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff && !rready;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (awvalid && awready_ff)
		begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = awaddr;
		end
		if (wvalid && wready_ff)
		begin
			nxt_w_got = 1'b1;
			nxt_wbyte = wdata[7:0];
			nxt_wstrb0 = wstrb[0];
		end
		if (wr_fire)
		begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = (wr_idx == standby_pkg::IDX_NONE) ?
				standby_pkg::RESP_SLVERR : standby_pkg::RESP_OKAY;
		end
		if (arvalid && arready_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = (rd_idx == standby_pkg::IDX_NONE) ?
				standby_pkg::RESP_SLVERR : standby_pkg::RESP_OKAY;
			case (rd_idx)
				standby_pkg::IDX_PMC: nxt_rdata = {29'h0, mif.pmc};
				standby_pkg::IDX_WDCFG: nxt_rdata = {24'h0, wdcfg_ff};
				standby_pkg::IDX_WDCTL: nxt_rdata = {24'h0, wdctl_ff};
				standby_pkg::IDX_OSCCTL: nxt_rdata = {24'h0, oscctl_ff};
				standby_pkg::IDX_STATUS: nxt_rdata = {26'h0, mif.state, osc_out_ff};
				standby_pkg::IDX_OSCRUN: nxt_rdata = {28'h0, oscrun_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
		nxt_awready = !nxt_aw_got && !nxt_bvalid;
		nxt_wready = !nxt_w_got && !nxt_bvalid;
		nxt_arready = !nxt_rvalid;
	end

	// Bus state registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			w_got_ff <= 1'b0;
			wbyte_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= 2'h0;
		end
		else
		begin
			aw_got_ff <= nxt_aw_got;
			awaddr_ff <= nxt_awaddr;
			w_got_ff <= nxt_w_got;
			wbyte_ff <= nxt_wbyte;
			wstrb0_ff <= nxt_wstrb0;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog and oscillator registers with standby entry side effects
	always_comb
	begin
		nxt_wdcfg = wdcfg_ff;
		nxt_wdctl = wdctl_ff;
		nxt_oscctl = oscctl_ff;
		nxt_oscrun = oscrun_ff;
		if (wr_fire && wr_lane)
		begin
			case (wr_idx)
				standby_pkg::IDX_WDCFG: nxt_wdcfg = wbyte_ff;
				standby_pkg::IDX_WDCTL: nxt_wdctl = wbyte_ff;
				standby_pkg::IDX_OSCCTL: nxt_oscctl = wbyte_ff;
				// Oscillator choice frozen while in standby
				standby_pkg::IDX_OSCRUN: nxt_oscrun =
					(mif.state == standby_pkg::ST_NORMAL) ? wbyte_ff[3:0] : oscrun_ff;
				default: nxt_oscrun = oscrun_ff;
			endcase
		end
		if (mif.enter_any && wdcfg_ff[standby_pkg::WDCFG_ARM_BIT])
		begin
			nxt_wdcfg = wdcfg_ff & ~standby_pkg::WDCFG_CLR_MASK;
		end
		if (mif.enter_any && !wdctl_ff[standby_pkg::WDCTL_SEL4_BIT]
			&& wdctl_ff[standby_pkg::WDCTL_SEL3_BIT])
		begin
			nxt_wdctl[standby_pkg::WDCTL_CLR_BIT] = 1'b0;
		end
		if (mif.enter_full)
		begin
			nxt_oscctl = oscctl_ff & ~standby_pkg::OSCCTL_CLR_MASK;
			// Main and RC come back running after the wake
			nxt_oscrun[standby_pkg::OSC_MAIN] = 1'b1;
			nxt_oscrun[standby_pkg::OSC_RC] = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (mif.rst_any)
		begin
			wdcfg_ff <= standby_pkg::WDCFG_RST;
			wdctl_ff <= standby_pkg::WDCTL_RST;
			oscctl_ff <= standby_pkg::OSCCTL_RST;
			oscrun_ff <= standby_pkg::OSCRUN_RST;
		end
		else
		begin
			wdcfg_ff <= nxt_wdcfg;
			wdctl_ff <= nxt_wdctl;
			oscctl_ff <= nxt_oscctl;
			oscrun_ff <= nxt_oscrun;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock gating and CPU control outputs
	always_comb
	begin
		nxt_osc_out = oscrun_ff;
		nxt_cpu_halt = mif.state != standby_pkg::ST_NORMAL;
		nxt_bt_stop = 1'b0;
		nxt_periph_stop = 1'b0;
		case (mif.state)
			standby_pkg::ST_DEEP_FULL:
			begin
				nxt_osc_out = 4'h0;
				nxt_bt_stop = 1'b1;
				nxt_periph_stop = 1'b1;
			end
			standby_pkg::ST_DEEP_SUB:
			begin
				nxt_osc_out = oscrun_ff & (4'h1 << standby_pkg::OSC_SUB);
				nxt_periph_stop = 1'b1;
			end
			default: nxt_osc_out = oscrun_ff;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			osc_out_ff <= standby_pkg::OSCRUN_RST;
			cpu_halt_ff <= 1'b0;
			bt_stop_ff <= 1'b0;
			periph_stop_ff <= 1'b0;
			cpu_reset_ff <= 1'b1;
		end
		else
		begin
			osc_out_ff <= nxt_osc_out;
			cpu_halt_ff <= nxt_cpu_halt;
			bt_stop_ff <= nxt_bt_stop;
			periph_stop_ff <= nxt_periph_stop;
			cpu_reset_ff <= mif.rst_any;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign cpu_reset = cpu_reset_ff;
	assign cpu_halt = cpu_halt_ff;
	assign {pll_osc_run, sub_osc_run, rc_osc_run, main_osc_run} = osc_out_ff; // Bits 3 to 0
	assign base_timer_stop = bt_stop_ff;
	assign periph_stop = periph_stop_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_wdcfg_entry_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.enter_any && wdcfg_ff[4] && !mif.rst_any) |=> (wdcfg_ff[2:0] == 3'h0))
		else $error("watchdog_config low bits not cleared");
	chk_wdctl_entry_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.enter_any && wdctl_ff[4:3] == 2'h1 && !mif.rst_any) |=> !wdctl_ff[5])
		else $error("watchdog_control bit 5 not cleared");
	chk_oscctl_entry_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.enter_full && !mif.rst_any) |=> ((oscctl_ff & 8'h33) == 8'h00))
		else $error("oscillator_control bits not cleared");
	chk_full_osc_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.state == standby_pkg::ST_DEEP_FULL) |=> (osc_out_ff == 4'h0 && bt_stop_ff))
		else $error("oscillator running in full deep standby");
	chk_sub_retain: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.state == standby_pkg::ST_DEEP_SUB)
		|=> (!main_osc_run && !rc_osc_run && !pll_osc_run && !bt_stop_ff
			&& sub_osc_run == $past(oscrun_ff[2])))
		else $error("subclock standby oscillators wrong");
	chk_cpu_stop: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(mif.state != standby_pkg::ST_NORMAL) |=> cpu_halt)
		else $error("cpu not halted in standby");
	chk_cpu_reset: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(watchdog_reset || !rst_sync2_ff) |=> cpu_reset)
		else $error("cpu reset not raised");

endmodule // standby_mode_controller

`default_nettype wire

// ===== dv/standby_mode_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end

module standby_mode_controller_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic awready, wready, bvalid, arready, rvalid;
	logic rst_pin_n, wake, irq_accept, watchdog_reset;
	logic cpu_reset, cpu_halt, main_osc_run, rc_osc_run, sub_osc_run, pll_osc_run;
	logic base_timer_stop, periph_stop;
	// Bench model of the registers
	logic [7:0] pmc_m, wdcfg_m, wdctl_m, oscctl_m, oscrun_m;
	int error_cnt, total_checks;

	standby_mode_controller standby_mode_controller_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .external_reset_pin_n(rst_pin_n),
		.port0_wake_interrupt(wake), .irq_accept(irq_accept), .watchdog_reset(watchdog_reset),
		.cpu_reset(cpu_reset), .cpu_halt(cpu_halt), .main_osc_run(main_osc_run),
		.rc_osc_run(rc_osc_run), .sub_osc_run(sub_osc_run), .pll_osc_run(pll_osc_run),
		.base_timer_stop(base_timer_stop), .periph_stop(periph_stop));

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w, b;
		int n;
		aw = 0;
		w = 0;
		b = 0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 50)
		begin
			@(posedge aclk);
			n++;
			if (b == 0 && bvalid === 1'b1 && aw && w)
			begin
				b = 1;
				rsp = bresp;
			end
			if (!aw && awready === 1'b1)
			begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		if (!b)
			`CHK("write done", 1'b1, 1'b0)
	endtask

	// AXI4-Lite read
	task automatic rd(input logic [7:0] a);
		bit ar, r;
		int n;
		ar = 0;
		r = 0;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r && n < 50)
		begin
			@(posedge aclk);
			n++;
			if (ar && rvalid === 1'b1)
			begin
				r = 1;
				rd_d = rdata;
				rsp = rresp;
			end
			if (!ar && arready === 1'b1)
			begin
				ar = 1;
				arvalid <= 1'b0;
			end
		end
		rready <= 1'b0;
		if (!r)
			`CHK("read done", 1'b1, 1'b0)
	endtask

	// Read a register and compare with the model
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		`CHK($sformatf("reg %0h", a), {24'h0, e}, rd_d)
	endtask

	// Expected {halt, timer stop, periph stop, pll, sub, rc, main} per mode
	function automatic logic [6:0] exp_out(input int md);
		case (md)
			1: exp_out = {3'b100, oscrun_m[3:0]};
			2: exp_out = {3'b101, 1'b0, oscrun_m[2], 2'b00};
			3: exp_out = 7'h70;
			default: exp_out = {3'b000, oscrun_m[3:0]};
		endcase
	endfunction

	task automatic chk_out(input int md);
		repeat (3) @(posedge aclk);
		`CHK("outputs", exp_out(md), {cpu_halt, base_timer_stop, periph_stop, pll_osc_run,
			sub_osc_run, rc_osc_run, main_osc_run})
	endtask

	// Side effects of any standby entry on the model
	task automatic entry(input bit full);
		if (wdcfg_m[4])
			wdcfg_m[2:0] = 3'h0;
		if (wdctl_m[4:3] == 2'b01)
			wdctl_m[5] = 1'b0;
		if (full)
			oscctl_m = oscctl_m & 8'hcc;
	endtask

	task automatic model_reset();
		pmc_m = 8'h00;
		wdcfg_m = 8'h00;
		wdctl_m = 8'h00;
		oscctl_m = 8'h00;
		oscrun_m = 8'h0b;
	endtask

	task automatic pulse_irq();
		@(posedge aclk);
		irq_accept <= 1'b1;
		@(posedge aclk);
		irq_accept <= 1'b0;
	endtask

	task automatic pulse_wake();
		@(posedge aclk);
		wake <= 1'b1;
		repeat (6) @(posedge aclk);
		wake <= 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, irq_accept, watchdog_reset, wake} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		rst_pin_n = 1'b1;
		aresetn = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		void'($urandom(32'h2243));
		model_reset();
		wstrb = 4'h1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset state
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_reg(standby_pkg::OSCRUN_OFS, oscrun_m);
		chk_out(0);
		$display("test reset done");
		// Light standby, all four watchdog_control bit 4..3 settings
		for (int i = 0; i < 4; i++)
		begin
			wdcfg_m = 8'($urandom) & 8'hef | {3'h0, i[0], 4'h0};
			wdctl_m = 8'($urandom) & 8'he7 | 8'h20 | {3'h0, i[1:0], 3'h0};
			wr(standby_pkg::WDCFG_OFS, {24'h0, wdcfg_m});
			wr(standby_pkg::WDCTL_OFS, {24'h0, wdctl_m});
			wr(standby_pkg::PMC_OFS, 32'h1);
			pmc_m = 8'h01;
			entry(0);
			chk_out(1);
			chk_reg(standby_pkg::WDCFG_OFS, wdcfg_m);
			chk_reg(standby_pkg::WDCTL_OFS, wdctl_m);
			pulse_irq();
			pmc_m = 8'h00;
			chk_reg(standby_pkg::PMC_OFS, pmc_m);
			chk_out(0);
		end
		$display("test light done");
		// Full deep standby and wake
		oscctl_m = 8'($urandom);
		oscrun_m = 8'($urandom) & 8'h0f;
		wdcfg_m = 8'h17;
		wr(standby_pkg::OSCCTL_OFS, {24'h0, oscctl_m});
		wr(standby_pkg::OSCRUN_OFS, {24'h0, oscrun_m});
		wr(standby_pkg::WDCFG_OFS, {24'h0, wdcfg_m});
		wr(standby_pkg::PMC_OFS, 32'h2);
		pmc_m = 8'h03;
		entry(1);
		chk_out(3);
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_reg(standby_pkg::OSCCTL_OFS, oscctl_m);
		chk_reg(standby_pkg::WDCFG_OFS, wdcfg_m);
		pulse_wake();
		pmc_m = 8'h01;
		oscrun_m = oscrun_m | 8'h03;
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_out(1);
		pulse_irq();
		$display("test full deep done");
		// Subclock-retaining standby
		oscctl_m = 8'($urandom);
		oscrun_m = 8'($urandom) & 8'h0f | 8'h04;
		wr(standby_pkg::OSCCTL_OFS, {24'h0, oscctl_m});
		wr(standby_pkg::OSCRUN_OFS, {24'h0, oscrun_m});
		wr(standby_pkg::PMC_OFS, 32'h6);
		pmc_m = 8'h07;
		entry(0);
		chk_out(2);
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_reg(standby_pkg::OSCCTL_OFS, oscctl_m);
		pulse_wake();
		pmc_m = 8'h05;
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_out(1);
		pulse_irq();
		pmc_m = 8'h04;
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		wr(standby_pkg::PMC_OFS, 32'h0);
		$display("test subclock done");
		// Watchdog reset in light standby
		wr(standby_pkg::PMC_OFS, 32'h1);
		@(posedge aclk);
		watchdog_reset <= 1'b1;
		@(posedge aclk);
		watchdog_reset <= 1'b0;
		#1 `CHK("cpu_reset", 1'b1, cpu_reset)
		model_reset();
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_out(0);
		// Reset pin in full deep standby
		wr(standby_pkg::PMC_OFS, 32'h2);
		@(posedge aclk);
		rst_pin_n <= 1'b0;
		repeat (4) @(posedge aclk);
		rst_pin_n <= 1'b1;
		chk_reg(standby_pkg::PMC_OFS, pmc_m);
		chk_out(0);
		$display("test resets done");
		// Unmapped places
		rd(8'h18);
		`CHK("unmapped read", 34'h200000000, {rsp, rd_d})
		wr(8'h1c, 32'h5a);
		`CHK("unmapped write", 2'h2, rsp)
		$display("test unmapped done");
		tally_and_finish();
	end
endmodule // standby_mode_controller_tb

`default_nettype wire
